//--- logic/tds_status.sv
/*
 * Status byte logic: two flag bytes, soft error and underrun counters, and
 * the byte-by-byte status read handshake toward the host controller.
 * Assumes the tape engine gives one-cycle event pulses on clk, command
 * decode hands over each accepted command byte, and host lines are async.
 */
`timescale 1ns/100ps
module tds_status
	import tds_pkg::*;
#(
	parameter int NODATA_TIMEOUT = NODATA_CYCLES
)(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Host handshake pins, active low request
	input  wire logic       hostRequest_n,
	output logic            devReady_n,
	output logic            devToHost_n,
	output logic            alert_n,
	output logic [7:0]      statusData,
	// Accepted command byte from decode
	input  wire logic       cmdValid,
	input  wire logic [7:0] cmdCode,
	// Drive condition levels
	input  wire logic       atBot,
	input  wire logic       atEndMedia,
	input  wire logic       writeProtect,
	input  wire logic       driveOffline,
	input  wire logic       noCartridge,
	input  wire logic       onlineLine,
	input  wire logic       writeSeq,
	input  wire logic       readSeq,
	input  wire logic       driveSelected,
	// Tape engine event pulses, and the block search level
	input  wire logic       blockRetry,
	input  wire logic       blockDone,
	input  wire logic       blockSearch,
	input  wire logic       blockFound,
	input  wire logic       fileMarkSeen,
	input  wire logic       markerLost,
	input  wire logic       rewriteBlock,
	input  wire logic       readRetryBlock,
	input  wire logic       writeStall,
	input  wire logic       readStall,
	// Busy while status bytes are on the bus
	output logic            statusBusy
);
	initial
	begin
		if (NODATA_TIMEOUT < 1)
			$error("NODATA_TIMEOUT must be positive");
	end

	// ****************************************************************
	// Request pin synchroniser
	// ****************************************************************
	logic reqMeta_r;
	logic reqSync_r;
	always_ff @(posedge clk)
	begin
		reqMeta_r <= ~hostRequest_n;
		reqSync_r <= reqMeta_r;
	end

	// ****************************************************************
	// Status read sequencer
	// ****************************************************************
	tds_state_t state_r;
	logic [2:0] byteIdx_r;
	logic       readDone;
	logic       startRead;
	assign startRead = cmdValid && (cmdCode == CMD_STATUS) && (state_r == ST_IDLE);
	assign readDone  = (state_r == ST_DONE);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_r   <= ST_IDLE;
			byteIdx_r <= BYTE_FLAGS_LOW;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					byteIdx_r <= BYTE_FLAGS_LOW;
					if (startRead)
						state_r <= ST_SHOW;
				end
				ST_SHOW:
				begin
					if (reqSync_r)
						state_r <= ST_HOLD;
				end
				ST_HOLD:
				begin
					if (!reqSync_r)
					begin
						if (byteIdx_r == BYTE_LAST)
							state_r <= ST_DONE;
						else
						begin
							byteIdx_r <= byteIdx_r + 3'h1;
							state_r   <= ST_SHOW;
						end
					end
				end
				ST_DONE:
					state_r <= ST_IDLE;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Command checks
	// ****************************************************************
	logic illegalCmd;
	logic selOneHot;
	assign selOneHot = (cmdCode[3:0] == 4'h1) || (cmdCode[3:0] == 4'h2) ||
		(cmdCode[3:0] == 4'h4) || (cmdCode[3:0] == 4'h8);
	always_comb
	begin
		illegalCmd = 1'b0;
		if (cmdValid && cmdCode != CMD_STATUS)
		begin
			if (cmdCode[7:5] == CT_SELECT && (!selOneHot || cmdCode[7:5] != CT_SELECT))
				illegalCmd = 1'b1;
			if (cmdCode[7:5] == CT_SELECT && driveSelected && !atBot)
				illegalCmd = 1'b1;
			if (cmdCode[7:5] == CT_POSITION && cmdCode != CMD_BOT &&
				cmdCode != CMD_ERASE && cmdCode != CMD_RETENSION)
				illegalCmd = 1'b1;
			if (!onlineLine && (cmdCode == CMD_WRITE || cmdCode == CMD_WRITE_FM ||
				cmdCode == CMD_READ || cmdCode == CMD_READ_FM))
				illegalCmd = 1'b1;
			if (writeSeq && cmdCode != CMD_WRITE && cmdCode != CMD_WRITE_FM)
				illegalCmd = 1'b1;
			if (readSeq && cmdCode != CMD_READ && cmdCode != CMD_READ_FM)
				illegalCmd = 1'b1;
		end
	end

	// ****************************************************************
	// Retry and no-data timing
	// ****************************************************************
	logic [4:0]  retryCnt_r;
	logic        retryWarn;
	logic        retryHard;
	logic [31:0] searchCnt_r;
	logic        noDataHit;
	assign retryWarn = blockRetry && (retryCnt_r == 5'(RETRY_WARN - 1));
	assign retryHard = blockRetry && (retryCnt_r == 5'(RETRY_HARD - 1));
	assign noDataHit = blockSearch && !blockFound && (searchCnt_r == 32'(NODATA_TIMEOUT - 1));

	always_ff @(posedge clk)
	begin
		if (sys_rst || blockDone)
			retryCnt_r <= 5'h00;
		else if (blockRetry && retryCnt_r != 5'h1F)
			retryCnt_r <= retryCnt_r + 5'h01;
	end

	// Counter stops at the limit so one search reports once
	always_ff @(posedge clk)
	begin
		if (sys_rst || !blockSearch || blockFound)
			searchCnt_r <= 32'h0;
		else if (searchCnt_r != 32'(NODATA_TIMEOUT))
			searchCnt_r <= searchCnt_r + 32'h1;
	end

	// ****************************************************************
	// Sticky flags: set wins over the read clear
	// ****************************************************************
	logic [7:0] hiSticky_r;
	logic [7:0] loSticky_r;
	logic       endMedia_r;
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			hiSticky_r <= 8'h01;
		else
		begin
			hiSticky_r[HI_RESET_SEEN]  <= hiSticky_r[HI_RESET_SEEN] && !readDone;
			hiSticky_r[HI_MANY_RETRY]  <= retryWarn || (hiSticky_r[HI_MANY_RETRY] && !readDone);
			hiSticky_r[HI_NO_DATA]     <= noDataHit || (hiSticky_r[HI_NO_DATA] && !readDone);
			hiSticky_r[HI_ILLEGAL_CMD] <= illegalCmd || (hiSticky_r[HI_ILLEGAL_CMD] && !readDone);
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			loSticky_r <= FLAGS_RESET;
		else
		begin
			loSticky_r[LO_FILE_MARK]   <= (fileMarkSeen && (readSeq || blockSearch)) ||
				(loSticky_r[LO_FILE_MARK] && !readDone);
			loSticky_r[LO_MARKER_LOST] <= markerLost || (loSticky_r[LO_MARKER_LOST] && !readDone);
			loSticky_r[LO_HARD_ERROR]  <= retryHard || (loSticky_r[LO_HARD_ERROR] && !readDone);
		end
	end

	// End of media only latches while writing, drops when leaving the zone
	always_ff @(posedge clk)
	begin
		if (sys_rst || !atEndMedia)
			endMedia_r <= 1'b0;
		else if (writeSeq)
			endMedia_r <= 1'b1;
	end

	// ****************************************************************
	// Soft error and underrun counters
	// ****************************************************************
	logic [COUNT_W-1:0] softCnt_r;
	logic [COUNT_W-1:0] undrCnt_r;
	logic               softInc;
	logic               undrInc;
	assign softInc = (writeSeq && rewriteBlock) || (readSeq && readRetryBlock);
	assign undrInc = (writeSeq && writeStall) || (readSeq && readStall);

	// Counts saturate rather than wrap, so a long run never looks clean
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			softCnt_r <= COUNT_RESET;
		else if (readDone)
			softCnt_r <= softInc ? 16'h0001 : COUNT_RESET;
		else if (softInc && softCnt_r != 16'hFFFF)
			softCnt_r <= softCnt_r + 16'h0001;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			undrCnt_r <= COUNT_RESET;
		else if (readDone)
			undrCnt_r <= undrInc ? 16'h0001 : COUNT_RESET;
		else if (undrInc && undrCnt_r != 16'hFFFF)
			undrCnt_r <= undrCnt_r + 16'h0001;
	end

	// ****************************************************************
	// Byte assembly and outputs
	// ****************************************************************
	logic [7:0] hiByte;
	logic [7:0] loByte;
	always_comb
	begin
		hiByte = 8'h00;
		hiByte[HI_RESET_SEEN]  = hiSticky_r[HI_RESET_SEEN];
		hiByte[HI_AT_BOT]      = atBot;
		hiByte[HI_MANY_RETRY]  = hiSticky_r[HI_MANY_RETRY];
		hiByte[HI_NO_DATA]     = hiSticky_r[HI_NO_DATA];
		hiByte[HI_ILLEGAL_CMD] = hiSticky_r[HI_ILLEGAL_CMD];
		hiByte[SUMMARY_BIT]    = |hiByte[6:0];
		loByte = 8'h00;
		loByte[2:0]             = loSticky_r[2:0];
		loByte[LO_END_MEDIA]    = endMedia_r;
		loByte[LO_WR_PROTECT]   = writeProtect;
		loByte[LO_NOT_ONLINE]   = driveOffline;
		loByte[LO_NO_CARTRIDGE] = noCartridge;
		loByte[SUMMARY_BIT]     = |loByte[6:0];
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			statusData <= 8'h00;
		else
		begin
			case (byteIdx_r)
				BYTE_FLAGS_LOW:  statusData <= loByte;
				BYTE_FLAGS_HIGH: statusData <= hiByte;
				BYTE_SOFT_HIGH:  statusData <= softCnt_r[15:8];
				BYTE_SOFT_LOW:   statusData <= softCnt_r[7:0];
				BYTE_UNDR_HIGH:  statusData <= undrCnt_r[15:8];
				BYTE_UNDR_LOW:   statusData <= undrCnt_r[7:0];
				default:         statusData <= 8'h00;
			endcase
		end
	end

	// Beginning of tape stays out of the alert term
	assign alert_n     = ~(|hiByte[6:4] || hiByte[HI_RESET_SEEN] || loByte[SUMMARY_BIT]) ||
		(state_r != ST_IDLE);
	assign devReady_n  = ~(state_r == ST_SHOW);
	assign devToHost_n = ~(state_r == ST_SHOW || state_r == ST_HOLD);
	assign statusBusy  = (state_r != ST_IDLE);
endmodule : tds_status

//--- logic/tds_pkg.sv
/*
 * Package for the tape drive status byte block: bit positions, byte indices,
 * command codes and reset values.
 * Assumes one 50 MHz clock and an 8-bit parallel handshake bus.
 */
package tds_pkg;
	// ****************************************************************
	// Flag byte bit positions
	// ****************************************************************
	localparam int HI_RESET_SEEN   = 0;
	localparam int HI_AT_BOT       = 3;
	localparam int HI_MANY_RETRY   = 4;
	localparam int HI_NO_DATA      = 5;
	localparam int HI_ILLEGAL_CMD  = 6;
	localparam int LO_FILE_MARK    = 0;
	localparam int LO_MARKER_LOST  = 1;
	localparam int LO_HARD_ERROR   = 2;
	localparam int LO_END_MEDIA    = 3;
	localparam int LO_WR_PROTECT   = 4;
	localparam int LO_NOT_ONLINE   = 5;
	localparam int LO_NO_CARTRIDGE = 6;
	localparam int SUMMARY_BIT     = 7;

	// ****************************************************************
	// Byte order on the bus, and widths
	// ****************************************************************
	localparam logic [2:0] BYTE_FLAGS_LOW  = 3'h0;
	localparam logic [2:0] BYTE_FLAGS_HIGH = 3'h1;
	localparam logic [2:0] BYTE_SOFT_HIGH  = 3'h2;
	localparam logic [2:0] BYTE_SOFT_LOW   = 3'h3;
	localparam logic [2:0] BYTE_UNDR_HIGH  = 3'h4;
	localparam logic [2:0] BYTE_UNDR_LOW   = 3'h5;
	localparam logic [2:0] BYTE_LAST       = 3'h5;
	localparam int         COUNT_W         = 16;
	localparam logic [7:0] FLAGS_RESET     = 8'h00;
	localparam logic [15:0] COUNT_RESET    = 16'h0000;

	// ****************************************************************
	// Command codes
	// ****************************************************************
	localparam logic [2:0] CT_SELECT   = 3'h0;
	localparam logic [2:0] CT_POSITION = 3'h1;
	localparam logic [7:0] CMD_BOT       = 8'h21;
	localparam logic [7:0] CMD_ERASE     = 8'h22;
	localparam logic [7:0] CMD_RETENSION = 8'h24;
	localparam logic [7:0] CMD_WRITE     = 8'h40;
	localparam logic [7:0] CMD_WRITE_FM  = 8'h60;
	localparam logic [7:0] CMD_READ      = 8'h80;
	localparam logic [7:0] CMD_READ_FM   = 8'hA0;
	localparam logic [7:0] CMD_STATUS    = 8'hC0;

	// ****************************************************************
	// Timing and thresholds
	// ****************************************************************
	localparam int RETRY_WARN   = 8;
	localparam int RETRY_HARD   = 16;
	localparam int NODATA_BLKS  = 32;
	localparam int BLOCK_TIME_US = 10;
	localparam int CLK_MHZ      = 50;
	localparam int NODATA_CYCLES = NODATA_BLKS * BLOCK_TIME_US * CLK_MHZ;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHOW  = 2'b01,
		ST_HOLD  = 2'b11,
		ST_DONE  = 2'b10
	} tds_state_t;
endpackage : tds_pkg

//--- verif/tds_status_chk.sv
/* Checker for the status byte block.
   Assumes it is bound to tds_status and sees only its ports. */
`timescale 1ns/100ps
module tds_status_chk
	import tds_pkg::*;
(
	// Watched ports
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       hostRequest_n,
	input wire logic       devReady_n,
	input wire logic       devToHost_n,
	input wire logic       alert_n,
	input wire logic [7:0] statusData,
	input wire logic       cmdValid,
	input wire logic [7:0] cmdCode,
	input wire logic       statusBusy
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_start;
		cmdValid && cmdCode == CMD_STATUS && !statusBusy;
	endsequence
	sequence s_shown;
		!devReady_n && statusBusy;
	endsequence
	property p_start; s_start |=> s_shown; endproperty
	a_start: assert property (p_start) else $error("no ready after status");
	property p_cause; $rose(statusBusy) |-> $past(cmdValid) && $past(cmdCode) == CMD_STATUS; endproperty
	a_cause: assert property (p_cause) else $error("busy without status");
	// Sync delay of two flops: three idle samples keep ready up
	property p_stand;
		!devReady_n && hostRequest_n && $past(hostRequest_n) && $past(hostRequest_n, 2) |=> !devReady_n;
	endproperty
	a_stand: assert property (p_stand) else $error("ready dropped early");
	property p_ack; $fell(hostRequest_n) && !devReady_n |-> ##[1:4] devReady_n; endproperty
	a_ack: assert property (p_ack) else $error("request not answered");
	property p_dir; !devReady_n |-> !devToHost_n; endproperty
	a_dir: assert property (p_dir) else $error("byte without direction");
	property p_quiet; !devToHost_n |-> alert_n && statusBusy; endproperty
	a_quiet: assert property (p_quiet) else $error("alert during read");
	property p_hold; !devReady_n && $past(!devReady_n) && $past(!devReady_n, 2) |-> $stable(statusData); endproperty
	a_hold: assert property (p_hold) else $error("data moved");
	property p_rst; $fell(sys_rst) |-> !alert_n; endproperty
	a_rst: assert property (p_rst) else $error("no alert after reset");
	property p_nosel; cmdValid && cmdCode == 8'h00 && !statusBusy |-> ##[1:2] !alert_n; endproperty
	a_nosel: assert property (p_nosel) else $error("empty select not flagged");
endmodule : tds_status_chk
bind tds_status tds_status_chk tds_status_chk_i (.clk(clk), .sys_rst(sys_rst), .hostRequest_n(hostRequest_n),
	.devReady_n(devReady_n), .devToHost_n(devToHost_n), .alert_n(alert_n), .statusData(statusData),
	.cmdValid(cmdValid), .cmdCode(cmdCode), .statusBusy(statusBusy));

//--- verif/tds_host_model.sv
/* Host controller model for the status byte handshake.
   Assumes active low ready and request, one clock with the device. */
`timescale 1ns/100ps
module tds_host_model
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Handshake
	input  wire logic       devReady_n,
	input  wire logic [7:0] statusData,
	output logic            hostRequest_n,
	// Bench side: reply delay, captured bytes
	input  wire logic [1:0] slow,
	output logic [7:0]      got [6],
	output int              nRd
);
	// ****************************************
	// Byte handshake
	// ****************************************
	logic [1:0] wt;
	int         idx;
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			hostRequest_n <= #1 1'b1;
			wt <= 2'h0;
			idx <= 0;
			nRd <= 0;
		end
		else if (hostRequest_n && !devReady_n)
		begin
			wt <= wt + 2'h1;
			if (wt == slow)
			begin
				hostRequest_n <= #1 1'b0;
				wt <= 2'h0;
			end
		end
		// Byte taken at the edge where the request is answered
		else if (!hostRequest_n && devReady_n)
		begin
			got[idx] <= statusData;
			hostRequest_n <= #1 1'b1;
			idx <= (idx == 5) ? 0 : idx + 1;
			if (idx == 5)
				nRd <= nRd + 1;
		end
	end
endmodule : tds_host_model

//--- verif/test_tds_status.sv
/* Testbench for tds_status with the host model.
   Assumes a 50 MHz clock and a shortened no-data timeout. */
`timescale 1ns/100ps
module test_tds_status;
	import tds_pkg::*;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic       clk, sys_rst, hostRequest_n, devReady_n, devToHost_n, alert_n, cmdValid, statusBusy;
	logic [7:0] statusData, cmdCode;
	logic [9:0] lv, ev;
	logic [1:0] slow;
	logic [7:0] got [6];
	logic [13:0] tbl [17];
	logic [31:0] v;
	int         nRd, error_cnt, n_tests, a, b, c, d;
	localparam logic [9:0] BASE = 10'h020;
	tds_status #(.NODATA_TIMEOUT(20)) tds_status_i (.clk(clk), .sys_rst(sys_rst),
		.hostRequest_n(hostRequest_n), .devReady_n(devReady_n), .devToHost_n(devToHost_n),
		.alert_n(alert_n), .statusData(statusData), .cmdValid(cmdValid), .cmdCode(cmdCode),
		.atBot(lv[0]), .atEndMedia(lv[1]), .writeProtect(lv[2]), .driveOffline(lv[3]),
		.noCartridge(lv[4]), .onlineLine(lv[5]), .writeSeq(lv[6]), .readSeq(lv[7]),
		.driveSelected(lv[8]), .blockSearch(lv[9]), .blockRetry(ev[0]), .blockDone(ev[1]),
		.blockFound(ev[2]), .fileMarkSeen(ev[3]), .markerLost(ev[4]), .rewriteBlock(ev[5]),
		.readRetryBlock(ev[6]), .writeStall(ev[7]), .readStall(ev[8]), .statusBusy(statusBusy));
	tds_host_model tds_host_model_i (.clk(clk), .sys_rst(sys_rst), .devReady_n(devReady_n),
		.statusData(statusData), .hostRequest_n(hostRequest_n), .slow(slow), .got(got), .nRd(nRd));
	// ****************************************
	// Tasks
	// ****************************************
	function automatic logic [7:0] sum(input logic [7:0] x);
		return {|x[6:0], x[6:0]};
	endfunction : sum
	task step; @(posedge clk); #1; endtask : step
	task fire(input int k, input int n); repeat (n) begin ev[k] = 1; step; ev[k] = 0; step; end endtask : fire
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task rd;
		int r, k;
		r = nRd;
		k = 0;
		slow = $urandom % 4;
		cmdCode = CMD_STATUS;
		cmdValid = 1;
		step;
		cmdValid = 0;
		// Host may be slow: allow a long bounded wait
		while ((nRd == r || statusBusy !== 1'b0) && k < 400) begin step; k++; end
		if (k >= 400) chk("read done", 1, 0);
	endtask : rd
	task rdChk(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] sc, input logic [15:0] uc);
		rd;
		chk("low flags", sum(lo), got[0]);
		chk("high flags", sum(hi), got[1]);
		chk("soft hi", sc[15:8], got[2]);
		chk("soft lo", sc[7:0], got[3]);
		chk("underrun hi", uc[15:8], got[4]);
		chk("underrun lo", uc[7:0], got[5]);
	endtask : rdChk
	task wrap_up;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// ****************************************
	// Clock, watchdog, tests
	// ****************************************
	initial begin clk = 0; forever #10 clk = ~clk; end
	initial begin #1500000; error_cnt++; wrap_up; end
	initial
	begin
		{sys_rst, cmdValid, cmdCode, ev, slow} = 0;
		lv = BASE;
		sys_rst = 1;
		void'($urandom(97865));
		tbl = '{14'h2100, 14'h2103, 14'h2123, 14'h2040, 14'h20A0, 14'h2380, 14'h2560, 14'h2321,
			14'h2901, 14'h0101, 14'h0112, 14'h0122, 14'h0124, 14'h0140, 14'h0360, 14'h0580, 14'h1901};
		repeat (2) step;
		sys_rst = 0;
		step;
		chk("alert after reset", 0, alert_n);
		rdChk(0, 8'h01, 0, 0);
		rdChk(0, 0, 0, 0);
		$display("test 0 done");
		for (a = 0; a < 6; a++)
		begin
			v = a ? $urandom : 1;
			lv[0] = v[0];
			lv[1] = v[1];
			lv[4:2] = v[4:2];
			lv[6] = v[5];
			lv[7] = ~v[5];
			step;
			fire(3, v[6]);
			fire(4, v[7]);
			rdChk({v[4:2], v[1] & v[5], 1'b0, v[7], v[6] & ~v[5]}, {v[0], 3'h0}, 0, 0);
			rdChk({v[4:2], v[1] & v[5], 3'h0}, {v[0], 3'h0}, 0, 0);
			if (a == 0) chk("alert at bot", 1, alert_n);
			lv = BASE;
			step;
		end
		$display("test 1 done");
		b = $urandom_range(1, 30);
		c = $urandom_range(0, 9);
		d = $urandom_range(1, 12);
		lv[6] = 1;
		fire(5, b);
		fire(7, d);
		lv[6] = 0;
		lv[7] = 1;
		fire(6, c);
		fire(8, 3);
		lv = BASE;
		step;
		rdChk(0, 0, 16'(b + c), 16'(d + 3));
		rdChk(0, 0, 0, 0);
		$display("test 2 done");
		for (a = 7; a <= 16; a += (a == 8) ? 8 : 1)
		begin
			fire(1, 1);
			fire(0, a);
			rdChk({a >= 16, 2'h0}, {a >= 8, 4'h0}, 0, 0);
		end
		$display("test 3 done");
		for (a = 10; a <= 30; a += 20)
		begin
			lv[9] = 1;
			repeat (a) step;
			fire(2, 1);
			lv[9] = 0;
			rd;
			chk("no data", sum({a > 20, 5'h0}), got[1]);
		end
		$display("test 4 done");
		foreach (tbl[i])
		begin
			{lv[0], lv[8], lv[7], lv[6], lv[5]} = tbl[i][12:8];
			cmdCode = tbl[i][7:0];
			cmdValid = 1;
			step;
			cmdValid = 0;
			lv = BASE;
			step;
			rdChk(0, {tbl[i][13], 6'h0}, 0, 0);
		end
		$display("test 5 done");
		lv[6] = 1;
		fire(5, 2);
		lv = BASE;
		sys_rst = 1;
		step;
		sys_rst = 0;
		rdChk(0, 8'h01, 0, 0);
		$display("test 6 done");
		wrap_up;
	end
endmodule : test_tds_status
